// *** hw/cgc_buf_pwr.sv ***
/*
 ADC buffer power sequencer: always on, off, or per-conversion precharge.
 Assumes conv_start and conv_done are one-cycle pulses from the ADC sequencer.
*/
`timescale 1ns/1ns
module cgc_buf_pwr (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst_n,
	// Settings
	input  wire logic buf_en,
	input  wire logic prechg,
	// Conversion events
	input  wire logic conv_start,
	input  wire logic conv_done,
	// Power control
	output logic      buf_pwr
);
	logic active_q;
	logic active_d;
	logic pwr_d;

	assign active_d = conv_start ? 1'b1 : (conv_done ? 1'b0 : active_q);
	assign pwr_d    = buf_en && (!prechg || active_d);

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			active_q <= 1'b0;
			buf_pwr  <= 1'b0;
		end else begin
			active_q <= active_d;
			buf_pwr  <= pwr_d;
		end
	end

	a_buf_always_on: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL8
		(buf_en && !prechg) |=> buf_pwr)
		else $error("buffer not powered in always-on mode");

	a_buf_idle_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
		(buf_en && prechg && conv_done && !conv_start) |=> !buf_pwr)
		else $error("precharge buffer still up after conversion");

	a_buf_prechg_up: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL9
		(buf_en && prechg && conv_start) |=> buf_pwr)
		else $error("precharge buffer not up at conversion start");
endmodule

// *** hw/cgc_ctrl.sv ***
/*
 Converter general control register with frame decoding, pin configuration
 lock and DAC broadcast. Takes complete 16-bit serial words as one-cycle
 strobes; frame timing and readback live elsewhere.
*/
// Operation
// RL1 - A control word with D15 zero and address 0011 writes the general control register.
// RL2 - The host sends the reserved bit D10 as zero.
// RL3 - Bit 5 selects the ADC input range.
// RL4 - Bit 4 selects the DAC output range.
// RL5 - While bit 7 is one, writes to pin configuration registers are dropped.
// RL6 - While bit 7 is zero, pin configuration writes update normally.
// RL7 - Bit 8 enables the ADC buffer, off by default.
// RL8 - With bit 9 zero the enabled buffer stays powered and does no precharge.
// RL9 - With bit 9 one the enabled buffer is powered only around each conversion.
// RL10 - With bit 6 zero a DAC write updates only the addressed channel.
// RL11 - With bit 6 one a DAC write loads every channel with the same data.
// RL12 - D15 zero marks a control write, D15 one a DAC data write.
// RL13 - In a DAC write bits 14 to 11 carry the channel address; the code takes the channel from bits 13 to 11 and ignores bit 14.
// RL14 - Reserved bits 3 to 0 are written as zero and have no effect.
`timescale 1ns/1ns
module cgc_ctrl
	import cgc_pkg::*;
#(
	parameter int unsigned CHAN_N = cgc_pkg::CGC_CHAN_N,
	parameter int unsigned CHAN_W = cgc_pkg::CGC_CHAN_W,
	parameter int unsigned DATA_W = cgc_pkg::CGC_DATA_W
) (
	// Clock and reset
	input  wire logic                             sys_clk,
	input  wire logic                             rst_n,
	// Serial word strobe
	input  wire logic                             word_valid,
	input  wire logic [cgc_pkg::CGC_WORD_W-1:0]   word_data,
	// ADC sequencer events
	input  wire logic                             conv_start,
	input  wire logic                             conv_done,
	// DAC data read port
	input  wire logic [CHAN_W-1:0]                dac_rd_chan,
	output logic      [DATA_W-1:0]                dac_rd_data,
	// Control register state
	output logic      [cgc_pkg::CGC_WORD_W-1:0]   ctrl_reg,
	output logic                                  adc_range,
	output logic                                  dac_range,
	output logic                                  buf_pwr,
	// Pin configuration
	output logic      [7:0]                       adc_pin_cfg,
	output logic      [7:0]                       dac_pin_cfg,
	output logic      [7:0]                       pulldn_cfg,
	output logic      [7:0]                       gpo_cfg,
	output logic      [7:0]                       gpi_cfg,
	output logic      [7:0]                       od_cfg,
	output logic      [7:0]                       tri_cfg
);
	import cgc_pkg::*;

	function automatic logic is_pin_cfg(input logic [CGC_ADDR_W-1:0] a);
		return (a == CGC_OFS_ADC_PIN) || (a == CGC_OFS_DAC_PIN) ||
			(a == CGC_OFS_PULLDN) || (a == CGC_OFS_GPO_CFG) ||
			(a == CGC_OFS_GPI_CFG) || (a == CGC_OFS_OD_CFG) ||
			(a == CGC_OFS_TRI_CFG);
	endfunction

	// Frame decode
	wire logic                  is_dac_wr;
	wire logic [CGC_ADDR_W-1:0] addr;
	wire logic                  ctrl_wr;
	wire logic                  pin_wr;
	wire logic                  lock;
	wire logic                  bcast;
	wire logic [15:0]           ctrl_d;
	wire logic [7:0]            pin_val;

	assign is_dac_wr = word_data[CGC_MSB_POS]; // RL12
	assign addr      = word_data[CGC_ADDR_HI:CGC_ADDR_LO];
	assign ctrl_wr   = word_valid && !is_dac_wr && (addr == CGC_OFS_CTRL); // RL1
	assign lock      = ctrl_reg[CGC_BIT_LOCK];
	assign bcast     = ctrl_reg[CGC_BIT_BCAST];
	// Lock gates only pin config writes; other control writes still land
	assign pin_wr    = word_valid && !is_dac_wr && is_pin_cfg(addr) && !lock; // RL5 RL6
	// D10 and D3..D0 masked off so host slips cannot set them
	assign ctrl_d    = word_data & CGC_CTRL_MASK; // RL2 RL14
	assign pin_val   = word_data[7:0];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			ctrl_reg <= CGC_CTRL_RST;
		end else if (ctrl_wr) begin
			ctrl_reg <= ctrl_d; // RL1
		end
	end

	// Range outputs registered from control register bits, one cycle behind ctrl_reg
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_range <= 1'b0;
			dac_range <= 1'b0;
		end else begin
			adc_range <= ctrl_reg[CGC_BIT_ADC_RNG]; // RL3
			dac_range <= ctrl_reg[CGC_BIT_DAC_RNG]; // RL4
		end
	end

	// Pin configuration registers
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			adc_pin_cfg <= CGC_PIN_RST;
			dac_pin_cfg <= CGC_PIN_RST;
			pulldn_cfg  <= CGC_PULLDN_RST;
			gpo_cfg     <= CGC_PIN_RST;
			gpi_cfg     <= CGC_PIN_RST;
			od_cfg      <= CGC_PIN_RST;
			tri_cfg     <= CGC_PIN_RST;
		end else if (pin_wr) begin // RL5 RL6
			unique case (addr)
				CGC_OFS_ADC_PIN: adc_pin_cfg <= pin_val;
				CGC_OFS_DAC_PIN: dac_pin_cfg <= pin_val;
				CGC_OFS_PULLDN:  pulldn_cfg  <= pin_val;
				CGC_OFS_GPO_CFG: gpo_cfg     <= pin_val;
				CGC_OFS_GPI_CFG: gpi_cfg     <= pin_val;
				CGC_OFS_OD_CFG:  od_cfg      <= pin_val;
				CGC_OFS_TRI_CFG: tri_cfg     <= pin_val;
				default:         od_cfg      <= od_cfg;
			endcase
		end
	end

	// DAC data writes
	wire logic              dac_wr;
	wire logic [CHAN_W-1:0] dac_chan;
	wire logic [DATA_W-1:0] dac_val;

	assign dac_wr   = word_valid && is_dac_wr; // RL12
	assign dac_chan = CHAN_W'(addr); // RL13
	assign dac_val  = word_data[DATA_W-1:0];

	cgc_dac_mem #(
		.CHAN_N (CHAN_N),
		.CHAN_W (CHAN_W),
		.DATA_W (DATA_W)
	) u_dac_mem (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.wr_en   (dac_wr),
		.wr_all  (bcast), // RL10 RL11
		.wr_chan (dac_chan),
		.wr_data (dac_val),
		.rd_chan (dac_rd_chan),
		.rd_data (dac_rd_data)
	);

	cgc_buf_pwr u_buf_pwr (
		.sys_clk    (sys_clk),
		.rst_n      (rst_n),
		.buf_en     (ctrl_reg[CGC_BIT_BUF_EN]), // RL7
		.prechg     (ctrl_reg[CGC_BIT_PRECHG]), // RL8 RL9
		.conv_start (conv_start),
		.conv_done  (conv_done),
		.buf_pwr    (buf_pwr)
	);

	// Checks
	sequence s_ctrl_write;
		word_valid && !word_data[CGC_MSB_POS] && (addr == CGC_OFS_CTRL);
	endsequence

	sequence s_pin_open(logic [CGC_ADDR_W-1:0] ofs);
		word_valid && !is_dac_wr && (addr == ofs) && !lock;
	endsequence

	sequence s_pin_shut(logic [CGC_ADDR_W-1:0] ofs);
		word_valid && !is_dac_wr && (addr == ofs) && lock;
	endsequence

	// Read channel must hold while the registered read port catches up
	sequence s_dac_held(logic hit);
		(dac_wr && hit) ##1 $stable(dac_rd_chan);
	endsequence

	a_ctrl_load: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1
		s_ctrl_write
		|=> (ctrl_reg == $past(word_data & CGC_CTRL_MASK)))
		else $error("control word not loaded");

	a_ctrl_hold: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL1 RL12
		!ctrl_wr
		|=> $stable(ctrl_reg))
		else $error("control register changed without a control write");

	a_rsvd_zero: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL14
		(ctrl_reg & ~CGC_CTRL_MASK) == 16'h0000)
		else $error("reserved control bits set");

	a_adc_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
		s_ctrl_write
		|=> ##1 (adc_range == $past(word_data[CGC_BIT_ADC_RNG], 2)))
		else $error("adc range not following control bit");

	a_dac_range: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
		s_ctrl_write
		|=> ##1 (dac_range == $past(word_data[CGC_BIT_DAC_RNG], 2)))
		else $error("dac range not following control bit");

	a_adc_track: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL3
		1'b1
		|=> (adc_range == $past(ctrl_reg[CGC_BIT_ADC_RNG])))
		else $error("adc range drifted from register");

	a_dac_track: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL4
		1'b1
		|=> (dac_range == $past(ctrl_reg[CGC_BIT_DAC_RNG])))
		else $error("dac range drifted from register");

	a_lock_holds: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_DAC_PIN)
		|=> $stable(dac_pin_cfg))
		else $error("pin config changed while locked");

	a_lock_adc: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_ADC_PIN)
		|=> $stable(adc_pin_cfg))
		else $error("adc pin config changed while locked");

	a_lock_pulldn: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_PULLDN)
		|=> $stable(pulldn_cfg))
		else $error("pull-down config changed while locked");

	a_lock_gpo: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_GPO_CFG)
		|=> $stable(gpo_cfg))
		else $error("output config changed while locked");

	a_lock_gpi: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_GPI_CFG)
		|=> $stable(gpi_cfg))
		else $error("input config changed while locked");

	a_lock_od: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_OD_CFG)
		|=> $stable(od_cfg))
		else $error("open-drain config changed while locked");

	a_lock_tri: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		s_pin_shut(CGC_OFS_TRI_CFG)
		|=> $stable(tri_cfg))
		else $error("three-state config changed while locked");

	a_unlock_wr: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_ADC_PIN)
		|=> (adc_pin_cfg == $past(word_data[7:0])))
		else $error("pin config write lost while unlocked");

	a_open_dac: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_DAC_PIN)
		|=> (dac_pin_cfg == $past(pin_val)))
		else $error("dac pin config write lost while unlocked");

	a_open_pulldn: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_PULLDN)
		|=> (pulldn_cfg == $past(pin_val)))
		else $error("pull-down config write lost while unlocked");

	a_open_gpo: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_GPO_CFG)
		|=> (gpo_cfg == $past(pin_val)))
		else $error("output config write lost while unlocked");

	a_open_gpi: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_GPI_CFG)
		|=> (gpi_cfg == $past(pin_val)))
		else $error("input config write lost while unlocked");

	a_open_od: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_OD_CFG)
		|=> (od_cfg == $past(pin_val)))
		else $error("open-drain config write lost while unlocked");

	a_open_tri: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL6
		s_pin_open(CGC_OFS_TRI_CFG)
		|=> (tri_cfg == $past(pin_val)))
		else $error("three-state config write lost while unlocked");

	// Refused words, locked or aimed elsewhere, leave every pin register alone
	a_pin_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL5
		!pin_wr
		|=> ($stable(adc_pin_cfg) && $stable(dac_pin_cfg) && $stable(pulldn_cfg) &&
			$stable(gpo_cfg) && $stable(gpi_cfg) && $stable(od_cfg) &&
			$stable(tri_cfg)))
		else $error("pin config changed without an accepted write");

	a_buf_off: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL7
		!ctrl_reg[CGC_BIT_BUF_EN]
		|=> !buf_pwr)
		else $error("buffer powered while disabled");

	a_bcast_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL11
		s_dac_held(bcast && (dac_rd_chan != dac_chan))
		|=> (dac_rd_data == $past(dac_val, 2)))
		else $error("broadcast write missed a channel");

	a_single_write: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL10
		s_dac_held(!bcast && (dac_rd_chan != dac_chan))
		|=> $stable(dac_rd_data))
		else $error("single write touched another channel");

	a_single_hit: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL10 RL13
		s_dac_held(!bcast && (dac_rd_chan == dac_chan))
		|=> (dac_rd_data == $past(dac_val, 2)))
		else $error("single write missed its channel");

	a_dac_idle: assert property (@(posedge sys_clk) disable iff (!rst_n) // RL12
		(!dac_wr ##1 $stable(dac_rd_chan))
		|=> $stable(dac_rd_data))
		else $error("dac data changed without a dac write");
endmodule

// *** hw/cgc_dac_mem.sv ***
/*
 DAC channel data store, one word per channel, registered read port.
 Assumes a single writer; broadcast sets all channels in one edge.
*/
`timescale 1ns/1ns
module cgc_dac_mem #(
	parameter int unsigned CHAN_N = 8,
	parameter int unsigned CHAN_W = 3,
	parameter int unsigned DATA_W = 12
) (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              rst_n,
	// Write port
	input  wire logic              wr_en,
	input  wire logic              wr_all,
	input  wire logic [CHAN_W-1:0] wr_chan,
	input  wire logic [DATA_W-1:0] wr_data,
	// Read port
	input  wire logic [CHAN_W-1:0] rd_chan,
	output logic      [DATA_W-1:0] rd_data
);
	logic [DATA_W-1:0] mem_q [CHAN_N];

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			for (int i = 0; i < CHAN_N; i++) begin
				mem_q[i] <= '0;
			end
		end else if (wr_en) begin
			for (int i = 0; i < CHAN_N; i++) begin
				if (wr_all || (wr_chan == CHAN_W'(i))) begin
					mem_q[i] <= wr_data;
				end
			end
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rd_data <= '0;
		end else begin
			rd_data <= mem_q[rd_chan];
		end
	end
endmodule

// *** hw/cgc_pkg.sv ***
/*
 Package for the converter general control block: frame layout, control
 register bit positions, reset values and widths.
 Assumes a 16-bit serial control word already assembled by a serial front end.
*/
package cgc_pkg;
	localparam int unsigned CGC_WORD_W      = 16;
	localparam int unsigned CGC_ADDR_W      = 4;
	localparam int unsigned CGC_CHAN_N      = 8;
	localparam int unsigned CGC_CHAN_W      = 3;
	localparam int unsigned CGC_DATA_W      = 12;
	// Frame fields
	localparam int unsigned CGC_MSB_POS     = 15;
	localparam int unsigned CGC_ADDR_HI     = 14;
	localparam int unsigned CGC_ADDR_LO     = 11;
	// Control register offsets (address field values)
	localparam logic [3:0]  CGC_OFS_NOP     = 4'h0;
	localparam logic [3:0]  CGC_OFS_CTRL    = 4'h3;
	localparam logic [3:0]  CGC_OFS_ADC_PIN = 4'h4;
	localparam logic [3:0]  CGC_OFS_DAC_PIN = 4'h5;
	localparam logic [3:0]  CGC_OFS_PULLDN  = 4'h6;
	localparam logic [3:0]  CGC_OFS_GPO_CFG = 4'h8;
	localparam logic [3:0]  CGC_OFS_GPI_CFG = 4'hA;
	localparam logic [3:0]  CGC_OFS_OD_CFG  = 4'hC;
	localparam logic [3:0]  CGC_OFS_TRI_CFG = 4'hD;
	// Control register bit positions
	localparam int unsigned CGC_BIT_RSVD10  = 10;
	localparam int unsigned CGC_BIT_PRECHG  = 9;
	localparam int unsigned CGC_BIT_BUF_EN  = 8;
	localparam int unsigned CGC_BIT_LOCK    = 7;
	localparam int unsigned CGC_BIT_BCAST   = 6;
	localparam int unsigned CGC_BIT_ADC_RNG = 5;
	localparam int unsigned CGC_BIT_DAC_RNG = 4;
	// Writable bits D9..D4
	localparam logic [15:0] CGC_CTRL_MASK   = 16'h03F0;
	localparam logic [15:0] CGC_CTRL_RST    = 16'h0000;
	localparam logic [7:0]  CGC_PIN_RST     = 8'h00;
	localparam logic [7:0]  CGC_PULLDN_RST  = 8'hFF;
	localparam logic [11:0] CGC_DAC_RST     = 12'h000;
	localparam int unsigned CGC_PIN_REGS    = 7;
endpackage

// *** sim/cgc_host_model.sv ***
/*
 Serial host stand-in: hands complete 16-bit words to the control block.
 Assumes the bench calls put() and that inputs move on the falling edge.
*/
`timescale 1ns/1ns
module cgc_host_model
	import cgc_pkg::*;
(
	// Clock
	input  wire logic        sys_clk,
	// Word strobe
	output logic             word_valid,
	output logic [15:0]      word_data
);
	initial begin
		word_valid = 1'b0;
		word_data  = 16'hA5A5;
	end

	// Raw mode lets a scenario send dirty reserved bits on purpose
	task automatic put(input logic [15:0] w, input bit raw);
		@(negedge sys_clk);
		if (!w[15] && w[14:11] == CGC_OFS_CTRL && !raw) begin
			w[10]  = 1'b0;
			w[3:0] = 4'h0;
		end
		word_valid <= 1'b1;
		word_data  <= w;
		@(negedge sys_clk);
		word_valid <= 1'b0;
		word_data  <= ~w; // Stale value never looks valid
	endtask
endmodule

// *** sim/tb.sv ***
/*
 Self-checking bench for the general control block.
 Assumes the host model drives the word port; expectations come from wr_model, buf_pwr ones from each conv() call.
*/
`timescale 1ns/1ns
module tb;
	import cgc_pkg::*;
	logic             sys_clk, rst_n, word_valid, conv_start, conv_done;
	logic             adc_range, dac_range, buf_pwr;
	logic [15:0]      word_data, ctrl_reg, exp_ctrl, w;
	logic [2:0]       dac_rd_chan;
	logic [11:0]      dac_rd_data;
	logic [11:0]      exp_dac [8];
	wire  [6:0][7:0]  cfg;
	logic [6:0][7:0]  exp_cfg;
	int               err_total, tests_run;
	localparam logic [3:0] PIN_OFS [7] = '{CGC_OFS_ADC_PIN, CGC_OFS_DAC_PIN,
		CGC_OFS_PULLDN, CGC_OFS_GPO_CFG, CGC_OFS_GPI_CFG, CGC_OFS_OD_CFG, CGC_OFS_TRI_CFG};

	cgc_host_model host_u (.sys_clk(sys_clk), .word_valid(word_valid), .word_data(word_data));
	cgc_ctrl dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .word_valid(word_valid),
		.word_data(word_data), .conv_start(conv_start), .conv_done(conv_done),
		.dac_rd_chan(dac_rd_chan), .dac_rd_data(dac_rd_data), .ctrl_reg(ctrl_reg),
		.adc_range(adc_range), .dac_range(dac_range), .buf_pwr(buf_pwr),
		.adc_pin_cfg(cfg[0]), .dac_pin_cfg(cfg[1]), .pulldn_cfg(cfg[2]), .gpo_cfg(cfg[3]),
		.gpi_cfg(cfg[4]), .od_cfg(cfg[5]), .tri_cfg(cfg[6]));

	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			err_total++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask

	task automatic end_sim;
		if (err_total == 0 && tests_run > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	// Lock and broadcast act on the state before this word
	function automatic void wr_model(logic [15:0] v);
		if (v[15]) begin
			for (int c = 0; c < 8; c++)
				if (exp_ctrl[6] || c == v[13:11]) exp_dac[c] = v[11:0];
		end else if (v[14:11] == CGC_OFS_CTRL)
			exp_ctrl = v & CGC_CTRL_MASK;
		else for (int i = 0; i < 7; i++)
			if (v[14:11] == PIN_OFS[i] && !exp_ctrl[7]) exp_cfg[i] = v[7:0];
	endfunction

	task automatic wr(logic [15:0] v, bit raw);
		host_u.put(v, raw);
		wr_model(v);
	endtask

	task automatic check_all;
		@(negedge sys_clk);
		chk("ctrl_reg", exp_ctrl, ctrl_reg);
		chk("adc_range", 16'(exp_ctrl[5]), 16'(adc_range));
		chk("dac_range", 16'(exp_ctrl[4]), 16'(dac_range));
		for (int i = 0; i < 7; i++)
			chk("pin_cfg", 16'(exp_cfg[i]), 16'(cfg[i]));
		for (int c = 0; c < 8; c++) begin
			dac_rd_chan = 3'(c);
			@(negedge sys_clk);
			chk("dac_data", 16'(exp_dac[c]), 16'(dac_rd_data));
		end
	endtask

	task automatic conv(logic s, logic d, logic e);
		conv_start = s;
		conv_done  = d;
		@(negedge sys_clk);
		conv_start = 1'b0;
		conv_done  = 1'b0;
		repeat (3) @(negedge sys_clk);
		chk("buf_pwr", 16'(e), 16'(buf_pwr));
	endtask

	initial begin
		#200000;
		err_total++;
		end_sim;
	end

	initial begin
		rst_n = 1'b0;
		conv_start = 1'b0;
		conv_done = 1'b0;
		dac_rd_chan = 3'h0;
		exp_ctrl = CGC_CTRL_RST;
		exp_cfg = '0;
		exp_cfg[2] = CGC_PULLDN_RST;
		for (int c = 0; c < 8; c++) exp_dac[c] = CGC_DAC_RST;
		err_total = 0;
		tests_run = 0;
		void'($urandom(25));
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		check_all;
		wr(16'h1C3F, 1'b1);
		check_all;
		// Lock, blocked pin write, broadcast, single channel
		wr(16'h1880, 1'b0); wr(16'h2055, 1'b0); wr(16'h30AA, 1'b0);
		wr(16'h2855, 1'b0); check_all;
		wr(16'h1840, 1'b0); wr(16'h2055, 1'b0); wr(16'hFFFF, 1'b0); check_all;
		wr(16'h1800, 1'b0); wr(16'hB123, 1'b0); wr(16'h0FFF, 1'b0);
		wr(16'hBF45, 1'b0); check_all;
		for (int n = 0; n < 24; n++) begin
			w = 16'($urandom);
			if (n % 3 == 0) w[15:11] = 5'b00011;
			if (n % 3 == 1) w[15:11] = {1'b0, PIN_OFS[$urandom % 7]};
			wr(w, 1'($urandom));
			check_all;
		end
		wr(16'h1900, 1'b0);
		conv(1'b0, 1'b0, 1'b1);
		wr(16'h1B00, 1'b0);
		conv(1'b0, 1'b0, 1'b0);
		conv(1'b1, 1'b0, 1'b1);
		conv(1'b0, 1'b1, 1'b0);
		conv(1'b1, 1'b1, 1'b1);
		wr(16'h1A00, 1'b0);
		conv(1'b1, 1'b0, 1'b0);
		end_sim;
	end
endmodule
